// [core/cid_pkg.sv]
// constants, encodings and the state type of the instruction decode block
// assumes a 32-bit AHB-Lite register bus and one 100 MHz core clock
`default_nettype none

package cid_pkg;

  // ************************************************************
  // register byte offsets (low ten address bits are decoded)
  // ************************************************************
  localparam logic [9:0] OFS_INSTR = 10'h000;
  localparam logic [9:0] OFS_STAT = 10'h004;
  localparam logic [9:0] OFS_WORK = 10'h008;
  localparam logic [9:0] OFS_PC = 10'h00c;
  localparam logic [9:0] OFS_PTR0 = 10'h010;
  localparam logic [9:0] OFS_PTR1 = 10'h014;
  localparam logic [9:0] OFS_OPTION = 10'h018;
  localparam logic [9:0] OFS_TRISTATE = 10'h01c;
  localparam logic [9:0] OFS_CYCLES = 10'h020;
  localparam logic [9:0] OFS_STACK = 10'h024;
  localparam logic [9:0] OFS_FILE = 10'h200;

  // ************************************************************
  // status register field positions
  // ************************************************************
  localparam int unsigned ST_CARRY = 0;
  localparam int unsigned ST_DIGIT = 1;
  localparam int unsigned ST_ZERO = 2;
  localparam int unsigned ST_PWRDN = 3;
  localparam int unsigned ST_TO = 4;
  localparam int unsigned ST_BUSY = 8;
  localparam int unsigned ST_STANDBY = 9;
  localparam int unsigned ST_UNSUP = 10;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [7:0] RST_WORK = 8'h00;
  localparam logic [14:0] RST_PC = 15'h0000;
  localparam logic [15:0] RST_PTR = 16'h0000;
  localparam logic [7:0] RST_OPTION = 8'hff;
  localparam logic [7:0] RST_TRISTATE = 8'hff;
  localparam logic RST_TO = 1'b1;
  localparam logic RST_PWRDN = 1'b1;

  // ************************************************************
  // opcode fields
  // ************************************************************
  localparam logic [1:0] CLS_MISC = 2'h0;
  localparam logic [1:0] CLS_LIT = 2'h3;
  localparam logic [13:0] OP_BR_WORK = 14'h000b;
  localparam logic [13:0] OP_CALL_WORK = 14'h000a;
  localparam logic [13:0] OP_OPTION = 14'h0062;
  localparam logic [13:0] OP_STANDBY = 14'h0063;
  localparam logic [11:0] OP_TRISTATE_HI = 12'h019;
  localparam logic [9:0] OP_INDIR_HI = 10'h001;
  localparam logic [3:0] OP_AND_FILE = 4'h5;
  localparam logic [3:0] OP_ADD_FILE = 4'h7;
  localparam logic [3:0] OP_RET_LIT = 4'h4;
  localparam logic [3:0] OP_AND_LIT = 4'h9;
  localparam logic [3:0] OP_ADD_LIT = 4'he;
  localparam logic [3:0] OP_PTRADD = 4'h1;
  localparam logic [3:0] OP_INDEXED = 4'hf;
  localparam logic [2:0] OP_REL_BRANCH = 3'h1;
  localparam logic [1:0] MM_PREINC = 2'h0;
  localparam logic [1:0] MM_PREDEC = 2'h1;
  localparam logic [1:0] MM_POSTINC = 2'h2;

  localparam int unsigned STACK_DEPTH = 8;
  localparam int unsigned FILE_DEPTH = 128;

  typedef enum logic [1:0] {
    CID_IDLE = 2'b00,
    CID_EXEC = 2'b01,
    CID_SECOND = 2'b11,
    CID_EXTRA = 2'b10
  } cid_state_e;

endpackage

`default_nettype wire

// [core/cid_core.sv]
// instruction decode and execute block with its register file behind AHB-Lite
// assumes one clock, an asynchronous active-high reset and a single bus master
//
// Local design decisions: the register offsets and the AHB-Lite interface to the registers.
`default_nettype none

module cid_core
  import cid_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // core side
  output logic standby
);

  // ************************************************************
  // bus slave state
  // ************************************************************
  logic wr_pend_q, wr_pend_d;
  logic rd_pend_q, rd_pend_d;
  logic [9:0] addr_q, addr_d;
  logic [31:0] hrdata_q, hrdata_d;
  logic hready_q, hready_d;
  logic take;
  logic bus_wr;

  // ************************************************************
  // execution state
  // ************************************************************
  cid_state_e state_q, state_d;
  logic [13:0] instr_q, instr_d;
  logic [7:0] work_q, work_d;
  logic [14:0] pc_q, pc_d;
  logic [15:0] ptr0_q, ptr0_d;
  logic [15:0] ptr1_q, ptr1_d;
  logic [7:0] option_q, option_d;
  logic [7:0] tristate_q [4];
  logic [7:0] tristate_d [4];
  logic c_q, c_d, digit_q, digit_d, z_q, z_d, to_q, to_d, pwrdn_q, pwrdn_d;
  logic stby_q, stby_d;
  logic unsup_q, unsup_d;
  logic extra_q, extra_d;
  logic [1:0] cycles_q, cycles_d;
  logic [2:0] sp_q, sp_d;

  // ************************************************************
  // memories
  // ************************************************************
  logic [7:0] file_mem [FILE_DEPTH];
  logic [14:0] stack_mem [STACK_DEPTH];
  logic file_we;
  logic [6:0] file_wa;
  logic [7:0] file_wd;
  logic stack_we;
  logic [14:0] stack_wd;

  // ************************************************************
  // helpers
  // ************************************************************
  // returns {carry, digit carry, sum}
  function automatic logic [9:0] add8(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    logic [4:0] h;
    s = {1'b0, a} + {1'b0, b};
    h = {1'b0, a[3:0]} + {1'b0, b[3:0]};
    return {s[8], h[4], s[7:0]};
  endfunction

  assign take = hsel & htrans[1] & hready;
  assign bus_wr = wr_pend_q & (state_q == CID_IDLE);

  // ************************************************************
  // read multiplexer
  // ************************************************************
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (addr_q >= OFS_FILE) begin
      rd_mux = {24'h00_0000, file_mem[addr_q[8:2]]};
    end else begin
      case (addr_q)
        OFS_INSTR: rd_mux = {18'h0_0000, instr_q};
        OFS_STAT: begin
          rd_mux[ST_CARRY] = c_q;
          rd_mux[ST_DIGIT] = digit_q;
          rd_mux[ST_ZERO] = z_q;
          rd_mux[ST_PWRDN] = pwrdn_q;
          rd_mux[ST_TO] = to_q;
          rd_mux[ST_BUSY] = (state_q != CID_IDLE);
          rd_mux[ST_STANDBY] = stby_q;
          rd_mux[ST_UNSUP] = unsup_q;
        end
        OFS_WORK: rd_mux = {24'h00_0000, work_q};
        OFS_PC: rd_mux = {17'h0_0000, pc_q};
        OFS_PTR0: rd_mux = {16'h0000, ptr0_q};
        OFS_PTR1: rd_mux = {16'h0000, ptr1_q};
        OFS_OPTION: rd_mux = {24'h00_0000, option_q};
        OFS_TRISTATE: rd_mux = {tristate_q[3], tristate_q[2], tristate_q[1], tristate_q[0]};
        OFS_CYCLES: rd_mux = {30'h0000_0000, cycles_q};
        OFS_STACK: rd_mux = {14'h0000, sp_q, stack_mem[sp_q - 3'd1]};
        default: rd_mux = 32'h0000_0000;
      endcase
    end
  end

  // ************************************************************
  // bus slave: writes take no wait, reads one wait state
  // ************************************************************
  always_comb begin
    wr_pend_d = 1'b0;
    rd_pend_d = 1'b0;
    addr_d = addr_q;
    hrdata_d = hrdata_q;
    hready_d = 1'b1;
    if (rd_pend_q) begin
      hrdata_d = rd_mux;
    end else if (take) begin
      addr_d = haddr[9:0];
      wr_pend_d = hwrite;
      rd_pend_d = ~hwrite;
      hready_d = hwrite;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q <= 10'h000;
      hrdata_q <= 32'h0000_0000;
      hready_q <= 1'b1;
    end else begin
      wr_pend_q <= wr_pend_d;
      rd_pend_q <= rd_pend_d;
      addr_q <= addr_d;
      hrdata_q <= hrdata_d;
      hready_q <= hready_d;
    end
  end

  // ************************************************************
  // decode and execute
  // ************************************************************
  logic [1:0] cls;
  logic [1:0] mm;
  logic ptr_sel;
  logic [15:0] ptr_cur, ptr_step, ind_addr, idx_addr, ptr_sum;
  logic [7:0] file_val, ind_val, idx_val;
  logic [9:0] sum_lit, sum_file;
  logic [7:0] and_lit, and_file;
  logic [14:0] pc_inc;
  logic two;

  always_comb begin
    cls = instr_q[13:12];
    mm = instr_q[1:0];
    // the inc/dec form carries n in bit 2, the indexed and add forms in bit 6
    ptr_sel = (cls == CLS_MISC) ? instr_q[2] : instr_q[6];
    ptr_cur = ptr_sel ? ptr1_q : ptr0_q;
    ptr_step = ptr_cur + ((mm == MM_PREDEC || mm[0]) ? 16'hffff : 16'h0001);
    ind_addr = (mm == MM_PREINC || mm == MM_PREDEC) ? ptr_step : ptr_cur;
    idx_addr = ptr_cur + {{10{instr_q[5]}}, instr_q[5:0]};
    ptr_sum = ptr_cur + {{10{instr_q[5]}}, instr_q[5:0]};
    file_val = file_mem[instr_q[6:0]];
    ind_val = file_mem[ind_addr[6:0]];
    idx_val = file_mem[idx_addr[6:0]];
    sum_lit = add8(work_q, instr_q[7:0]);
    sum_file = add8(work_q, file_val);
    and_lit = work_q & instr_q[7:0];
    and_file = work_q & file_val;
    pc_inc = pc_q + 15'd1;
  end

  always_comb begin
    state_d = state_q;
    instr_d = instr_q;
    work_d = work_q;
    pc_d = pc_q;
    ptr0_d = ptr0_q;
    ptr1_d = ptr1_q;
    option_d = option_q;
    tristate_d = tristate_q;
    c_d = c_q;
    digit_d = digit_q;
    z_d = z_q;
    to_d = to_q;
    pwrdn_d = pwrdn_q;
    stby_d = stby_q;
    unsup_d = unsup_q;
    extra_d = extra_q;
    cycles_d = cycles_q;
    sp_d = sp_q;
    file_we = 1'b0;
    file_wa = 7'h00;
    file_wd = 8'h00;
    stack_we = 1'b0;
    stack_wd = 15'h0000;
    two = 1'b0;
    case (state_q)
      CID_IDLE: begin
        if (bus_wr) begin
          if (addr_q >= OFS_FILE) begin
            file_we = 1'b1;
            file_wa = addr_q[8:2];
            file_wd = hwdata[7:0];
          end else begin
            case (addr_q)
              OFS_INSTR: begin
                instr_d = hwdata[13:0];
                stby_d = 1'b0;
                state_d = CID_EXEC;
              end
              OFS_STAT: begin
                c_d = hwdata[ST_CARRY];
                digit_d = hwdata[ST_DIGIT];
                z_d = hwdata[ST_ZERO];
              end
              OFS_WORK: work_d = hwdata[7:0];
              OFS_PC: pc_d = hwdata[14:0];
              OFS_PTR0: ptr0_d = hwdata[15:0];
              OFS_PTR1: ptr1_d = hwdata[15:0];
              default: ;
            endcase
          end
        end
      end
      CID_EXEC: begin
        pc_d = pc_inc;
        unsup_d = 1'b0;
        extra_d = 1'b0;
        cycles_d = 2'd1;
        case (cls)
          CLS_MISC: begin
            if (instr_q == OP_BR_WORK) begin
              pc_d = pc_inc + {7'h00, work_q};
              two = 1'b1;
            end else if (instr_q == OP_CALL_WORK) begin
              stack_we = 1'b1;
              stack_wd = pc_inc;
              sp_d = sp_q + 3'd1;
              pc_d = {pc_q[14:8], work_q};
              two = 1'b1;
            end else if (instr_q == OP_OPTION) begin
              option_d = work_q;
            end else if (instr_q == OP_STANDBY) begin
              stby_d = 1'b1;
              to_d = 1'b1;
              pwrdn_d = 1'b0;
            end else if (instr_q[13:2] == OP_TRISTATE_HI) begin
              tristate_d[instr_q[1:0]] = work_q;
            end else if (instr_q[13:4] == OP_INDIR_HI) begin
              if (ptr_sel) begin
                ptr1_d = ptr_step;
              end else begin
                ptr0_d = ptr_step;
              end
              extra_d = ind_addr[15];
              if (instr_q[3]) begin
                file_we = 1'b1;
                file_wa = ind_addr[6:0];
                file_wd = work_q;
              end else begin
                work_d = ind_val;
                z_d = (ind_val == 8'h00);
              end
            end else if (instr_q[11:8] == OP_AND_FILE || instr_q[11:8] == OP_ADD_FILE) begin
              if (instr_q[11:8] == OP_AND_FILE) begin
                z_d = (and_file == 8'h00);
                file_wd = and_file;
              end else begin
                {c_d, digit_d, file_wd} = sum_file;
                z_d = (sum_file[7:0] == 8'h00);
              end
              if (instr_q[7]) begin
                file_we = 1'b1;
                file_wa = instr_q[6:0];
              end else begin
                work_d = file_wd;
              end
            end else begin
              unsup_d = 1'b1;
            end
          end
          CLS_LIT: begin
            if (instr_q[11:9] == OP_REL_BRANCH) begin
              pc_d = pc_inc + {{6{instr_q[8]}}, instr_q[8:0]};
              two = 1'b1;
            end else if (instr_q[11:8] == OP_RET_LIT) begin
              work_d = instr_q[7:0];
              sp_d = sp_q - 3'd1;
              pc_d = stack_mem[sp_q - 3'd1];
              two = 1'b1;
            end else if (instr_q[11:8] == OP_AND_LIT) begin
              work_d = and_lit;
              z_d = (and_lit == 8'h00);
            end else if (instr_q[11:8] == OP_ADD_LIT) begin
              {c_d, digit_d, work_d} = sum_lit;
              z_d = (sum_lit[7:0] == 8'h00);
            end else if (instr_q[11:8] == OP_PTRADD && !instr_q[7]) begin
              if (ptr_sel) begin
                ptr1_d = ptr_sum;
              end else begin
                ptr0_d = ptr_sum;
              end
            end else if (instr_q[11:8] == OP_INDEXED) begin
              extra_d = idx_addr[15];
              if (instr_q[7]) begin
                file_we = 1'b1;
                file_wa = idx_addr[6:0];
                file_wd = work_q;
              end else begin
                work_d = idx_val;
                z_d = (idx_val == 8'h00);
              end
            end else begin
              unsup_d = 1'b1;
            end
          end
          default: unsup_d = 1'b1;
        endcase
        if (two) begin
          state_d = CID_SECOND;
        end else if (extra_d) begin
          state_d = CID_EXTRA;
        end else begin
          state_d = CID_IDLE;
        end
      end
      CID_SECOND: begin
        // flushed fetch slot: nothing changes but the count
        cycles_d = cycles_q + 2'd1;
        state_d = extra_q ? CID_EXTRA : CID_IDLE;
      end
      CID_EXTRA: begin
        cycles_d = cycles_q + 2'd1;
        state_d = CID_IDLE;
      end
      default: state_d = CID_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q <= CID_IDLE;
      instr_q <= 14'h0000;
      work_q <= RST_WORK;
      pc_q <= RST_PC;
      ptr0_q <= RST_PTR;
      ptr1_q <= RST_PTR;
      option_q <= RST_OPTION;
      tristate_q <= '{default: RST_TRISTATE};
      c_q <= 1'b0;
      digit_q <= 1'b0;
      z_q <= 1'b0;
      to_q <= RST_TO;
      pwrdn_q <= RST_PWRDN;
      stby_q <= 1'b0;
      unsup_q <= 1'b0;
      extra_q <= 1'b0;
      cycles_q <= 2'd0;
      sp_q <= 3'd0;
    end else begin
      state_q <= state_d;
      instr_q <= instr_d;
      work_q <= work_d;
      pc_q <= pc_d;
      ptr0_q <= ptr0_d;
      ptr1_q <= ptr1_d;
      option_q <= option_d;
      tristate_q <= tristate_d;
      c_q <= c_d;
      digit_q <= digit_d;
      z_q <= z_d;
      to_q <= to_d;
      pwrdn_q <= pwrdn_d;
      stby_q <= stby_d;
      unsup_q <= unsup_d;
      extra_q <= extra_d;
      cycles_q <= cycles_d;
      sp_q <= sp_d;
    end
  end

  // ************************************************************
  // memory write ports
  // ************************************************************
  always_ff @(posedge sys_clk) begin
    if (file_we) begin
      file_mem[file_wa] <= file_wd;
    end
    if (stack_we) begin
      stack_mem[sp_q] <= stack_wd;
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = hready_q;
  assign hresp = 1'b0;
  assign standby = stby_q;

endmodule

`default_nettype wire

// [testbench/cid_monitor.sv]
// bus handshake and standby pin checks for cid_core
// assumes hready is tied to hreadyout by the bench
`default_nettype none

module cid_monitor
  import cid_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // core side
  input wire logic standby
);
  logic take;
  logic iw_q;
  logic iw_d;

  assign take = hsel && htrans[1] && hready;

  // ************************************************************
  // marks the data phase of an instruction write
  // ************************************************************
  always_comb begin
    iw_d = iw_q;
    if (hready) begin
      iw_d = take && hwrite && (haddr[9:0] == OFS_INSTR);
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      iw_q <= 1'b0;
    end else begin
      iw_q <= iw_d;
    end
  end

  // ************************************************************
  // properties
  // ************************************************************
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence rd_wait;
    !hreadyout ##1 hreadyout;
  endsequence

  sequence stby_cmd;
    iw_q && hready && (hwdata[13:0] == OP_STANDBY);
  endsequence

  a_resp_okay: assert property (hresp == 1'b0)
    else $error("response not okay");
  a_read_wait: assert property (take && !hwrite |=> rd_wait)
    else $error("read wait not one cycle");
  a_write_nowait: assert property (take && hwrite |=> hreadyout)
    else $error("write data phase stalled");
  a_data_hold: assert property ($changed(hrdata) |-> $past(hreadyout) == 1'b0)
    else $error("read data changed outside a read");
  a_unmapped_zero: assert property (take && !hwrite && haddr[9:0] == 10'h100 |-> ##2 hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_cycles_range: assert property (take && !hwrite && haddr[9:0] == OFS_CYCLES |-> ##2 hrdata inside {32'h1, 32'h2, 32'h3})
    else $error("cycle count out of range");
  a_standby_rise: assert property (stby_cmd |-> ##[1:4] standby)
    else $error("standby not entered");
  a_standby_keep: assert property (standby && !iw_q |=> standby)
    else $error("standby dropped without instruction");
endmodule

bind cid_core cid_monitor cid_monitor_i (.sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .standby(standby));

`default_nettype wire

// [testbench/test_control_and_indirect_instruction_decode.sv]
// self-checking bench for cid_core over its ahb-lite register port
// assumes a single master and hready looped back from hreadyout
`default_nettype none

module test_control_and_indirect_instruction_decode
  import cid_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic standby;
  logic [31:0] q;
  int err_total = 0;
  int check_count = 0;

  always #5 sys_clk = ~sys_clk;

  cid_core cid_core_i (.sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .standby(standby));

  // ************************************************************
  // reporting
  // ************************************************************
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  // ************************************************************
  // bus master
  // ************************************************************
  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 20) begin
        err_total++;
        summarize();
      end
      @(posedge sys_clk);
    end
  endtask

  task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {22'h0, a};
    hwrite <= wr;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
  endtask

  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rdc(input logic [9:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(q, exp);
  endtask

  // writes one word, waits for idle, then checks the cycle count
  task automatic run(input logic [13:0] w, input logic [31:0] cyc);
    int n;
    n = 0;
    wr(OFS_INSTR, {18'h0, w});
    bus(1'b0, OFS_STAT, 32'h0);
    while (q[ST_BUSY] !== 1'b0) begin
      n++;
      if (n > 8) begin
        err_total++;
        summarize();
      end
      bus(1'b0, OFS_STAT, 32'h0);
    end
    rdc(OFS_CYCLES, cyc);
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  initial begin
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rdc(OFS_WORK, 32'h0);
    rdc(OFS_OPTION, 32'hff);
    rdc(OFS_TRISTATE, 32'hffffffff);
    rdc(OFS_STAT, 32'h18);
    wr(OFS_WORK, 32'hff);
    run(14'h3e01, 32'h1);
    rdc(OFS_WORK, 32'h0);
    rdc(OFS_STAT, 32'h1f);
    wr(OFS_STAT, 32'h3);
    wr(OFS_WORK, 32'hf0);
    run(14'h390f, 32'h1);
    rdc(OFS_WORK, 32'h0);
    rdc(OFS_STAT, 32'h1f);
    wr(10'h214, 32'h80);
    wr(OFS_WORK, 32'h80);
    wr(OFS_STAT, 32'h0);
    run(14'h0785, 32'h1);
    rdc(10'h214, 32'h0);
    rdc(OFS_WORK, 32'h80);
    rdc(OFS_STAT, 32'h1d);
    wr(10'h218, 32'hc3);
    wr(OFS_WORK, 32'h0f);
    run(14'h0506, 32'h1);
    rdc(OFS_WORK, 32'h03);
    rdc(10'h218, 32'hc3);
    rdc(OFS_STAT, 32'h19);
    wr(OFS_PC, 32'h10);
    run(14'h33fe, 32'h2);
    rdc(OFS_PC, 32'h0f);
    wr(OFS_PC, 32'h20);
    wr(OFS_WORK, 32'h05);
    run(14'h000b, 32'h2);
    rdc(OFS_PC, 32'h26);
    wr(OFS_PC, 32'h0123);
    wr(OFS_WORK, 32'h45);
    run(14'h000a, 32'h2);
    rdc(OFS_PC, 32'h0145);
    rdc(OFS_STACK, 32'h8124);
    run(14'h3477, 32'h2);
    rdc(OFS_PC, 32'h0124);
    rdc(OFS_WORK, 32'h77);
    wr(OFS_WORK, 32'h5a);
    run(14'h0062, 32'h1);
    wr(OFS_OPTION, 32'h0);
    rdc(OFS_OPTION, 32'h5a);
    for (int k = 0; k < 4; k++) begin
      wr(OFS_WORK, 32'h10 + k);
      run(14'h0064 + 14'(k), 32'h1);
    end
    rdc(OFS_TRISTATE, 32'h13121110);
    wr(OFS_PTR0, 32'h4);
    wr(OFS_STAT, 32'h0);
    run(14'h0010, 32'h1);
    rdc(OFS_PTR0, 32'h5);
    rdc(OFS_STAT, 32'h1c);
    wr(OFS_PTR1, 32'h7);
    wr(OFS_WORK, 32'ha5);
    run(14'h001f, 32'h1);
    rdc(10'h21c, 32'ha5);
    rdc(OFS_PTR1, 32'h6);
    rdc(OFS_STAT, 32'h1c);
    wr(OFS_PTR1, 32'h8);
    wr(OFS_WORK, 32'h0);
    run(14'h0015, 32'h1);
    rdc(OFS_WORK, 32'ha5);
    rdc(OFS_PTR1, 32'h7);
    rdc(OFS_STAT, 32'h18);
    run(14'h001a, 32'h1);
    rdc(10'h214, 32'ha5);
    rdc(OFS_PTR0, 32'h6);
    wr(OFS_PTR0, 32'h5);
    wr(OFS_PTR1, 32'h8008);
    wr(OFS_WORK, 32'h0);
    run(14'h3f7f, 32'h2);
    rdc(OFS_WORK, 32'ha5);
    rdc(OFS_STAT, 32'h18);
    run(14'h3f83, 32'h1);
    rdc(10'h220, 32'ha5);
    rdc(OFS_STAT, 32'h18);
    wr(OFS_PTR1, 32'hffff);
    run(14'h3141, 32'h1);
    rdc(OFS_PTR1, 32'h0);
    wr(OFS_PTR0, 32'h0);
    run(14'h3120, 32'h1);
    rdc(OFS_PTR0, 32'hffe0);
    rdc(OFS_STAT, 32'h18);
    run(14'h1000, 32'h1);
    rdc(OFS_STAT, 32'h418);
    wr(10'h100, 32'hff);
    rdc(10'h100, 32'h0);
    run(14'h0063, 32'h1);
    chk({31'h0, standby}, 32'h1);
    rdc(OFS_STAT, 32'h210);
    run(14'h0000, 32'h1);
    chk({31'h0, standby}, 32'h0);
    summarize();
  end
endmodule

`default_nettype wire
